// ### rmirq_regs.svh
`ifndef RMIRQ_REGS_SVH
`define RMIRQ_REGS_SVH
`define RMIRQ_OFS_ON_C_LOW 8'ha0
`define RMIRQ_OFS_ON_C_HIGH 8'ha1
`define RMIRQ_OFS_ON_D_LOW 8'ha2
`define RMIRQ_OFS_ON_D_HIGH 8'ha3
`define RMIRQ_OFS_EXT_CMD 8'ha4
`define RMIRQ_OFS_MODE_ONE 8'ha5
`define RMIRQ_OFS_MODE_ZERO 8'ha6
`define RMIRQ_OFS_PEAK 8'ha7
`define RMIRQ_OFS_IRQ_AB 8'ha8
`define RMIRQ_OFS_IRQ_CD 8'ha9
`define RMIRQ_RST_ON_LOW 8'h01
`define RMIRQ_RST_ON_HIGH 6'h00
`define RMIRQ_RST_MODE_ONE 6'h04
`define RMIRQ_RST_MODE_ZERO 8'h10
`define RMIRQ_RST_IRQ 8'hff
`define RMIRQ_CMD_GAIN 3
`define RMIRQ_CMD_FREQ 2
`define RMIRQ_CMD_TIMEOUT 1
`define RMIRQ_CMD_END 0
`define RMIRQ_M1_NEXT_CFG 5
`define RMIRQ_M1_NEXT_CH 4
`define RMIRQ_M1_INIT_CYCLE 3
`define RMIRQ_M1_INIT_FRAME 2
`define RMIRQ_M1_LOCK 1
`define RMIRQ_M1_XTAL 0
`define RMIRQ_M0_REINIT 6
`define RMIRQ_M0_HOLD 5
`define RMIRQ_M0_CLKOUT 4
`define RMIRQ_M0_MCS_HI 3
`define RMIRQ_M0_MCS_LO 2
`define RMIRQ_M0_SLRX 1
`define RMIRQ_ON_TIME_MAX 15'h4000
`define RMIRQ_TICK_PRESCALE 64
`define RMIRQ_HOP_CYCLES 16
`endif

// ### rmirq_pkg.sv
package rmirq_pkg;
  // Operating mode reported by the sequencer.
  typedef enum logic [1:0] {
    RMIRQ_MODE_SLAVE_SLEEP = 2'h0,
    RMIRQ_MODE_SELF_POLL = 2'h1,
    RMIRQ_MODE_RUN_SELF_POLL = 2'h2
  } rmirq_mode_t;
  // Where self polling resumes after a message end or timeout.
  typedef enum logic [1:0] {
    RMIRQ_RESUME_CFG_A = 2'h0,
    RMIRQ_RESUME_NEXT_CFG = 2'h1,
    RMIRQ_RESUME_NEXT_CH = 2'h2
  } rmirq_resume_t;
  // Hold exit sequence, Gray coded except for the return from HOP to RUN.
  typedef enum logic [1:0] {
    RMIRQ_HS_RUN = 2'b00,
    RMIRQ_HS_HOLD = 2'b01,
    RMIRQ_HS_HOP = 2'b11
  } rmirq_hold_t;
  // Receiver events of one configuration, in status nibble order.
  typedef struct packed {
    logic message_end;
    logic message_id_found;
    logic frame_sync_found;
    logic wake_found;
  } rmirq_evt_t;
  // Register access strobes from the serial front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmirq_req_t;
endpackage

// ### rmirq_top.sv
`timescale 1ns/1ps
`include "rmirq_regs.svh"
module rmirq_top import rmirq_pkg::*; #(
  parameter int TICK_PRESCALE = `RMIRQ_TICK_PRESCALE,
  parameter int HOP_CYCLES = `RMIRQ_HOP_CYCLES
) (
  input wire logic clk_sys, // System clock, 50 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire rmirq_req_t req, // Register write or read strobe.
  output logic [7:0] rdata, // Read data, valid the cycle after a read.
  input wire logic [7:0] reference_timer_setting, // Reference timer setting, zero is 256.
  output logic ref_tick, // One pulse per reference tick period.
  input wire logic on_time_start, // Start an on-time window.
  input wire logic on_time_sel_d, // Window for configuration D, else C.
  output logic on_time_busy, // On-time window running.
  output logic on_time_expired, // Pulse at the end of the window.
  output logic [14:0] on_time_c_ticks, // Configuration C on-time in ticks.
  output logic [14:0] on_time_d_ticks, // Configuration D on-time in ticks.
  input wire logic gain_freeze_source, // Gain freeze taken from command.
  input wire logic freq_freeze_source, // Frequency freeze taken from command.
  output logic gain_freeze, // Automatic gain control frozen.
  output logic freq_freeze, // Automatic frequency control frozen.
  input wire logic [1:0] external_processing_select, // External processing selection.
  input wire logic message_timeout_in, // Timeout from the internal chain.
  input wire logic message_end_in, // Message end from the internal chain.
  output logic message_timeout, // Timeout seen by the sequencer.
  output logic message_end, // Message end seen by the sequencer.
  input wire rmirq_mode_t op_mode, // Current operating mode.
  input wire logic single_channel, // Only one RF channel in use.
  output logic resume_valid, // Pulse: return to self polling.
  output rmirq_resume_t resume_kind, // Where self polling resumes.
  input wire logic slave_cycle_start, // Run mode slave cycle begins.
  input wire logic wake_to_run, // Wake-up found, switching to run.
  input wire logic frame_start, // Frame start detected.
  output logic queue_init, // Pulse: initialise data queue.
  input wire logic queue_release, // Release queue lock.
  output logic queue_locked, // Data queue and receive chain locked.
  output logic crystal_precise, // Crystal high precision while sleeping.
  input wire logic new_channel, // A new channel was programmed.
  output logic hold_state, // In register configuration hold.
  output logic synth_init, // Pulse: reinitialise the synthesiser.
  output logic rx_init, // Pulse: initialise the digital receiver.
  input wire logic prog_clk, // Programmable clock source.
  output logic clk_out, // Clock pin value.
  output logic clk_out_oe, // Clock pin driven.
  output logic [3:0] active_configs, // Configurations in use, bit per A to D.
  output logic receiver_sleep, // Slave receiver sleeping.
  output logic receiver_slave, // Slave receiver running.
  output logic [7:0] mode_zero, // Stored mode control zero.
  input wire logic [7:0] peak_level, // Live peak detector level.
  input wire logic cycle_end, // End of a configuration or channel cycle.
  input wire logic [1:0] evt_cfg, // Configuration of the events, A to D.
  input wire rmirq_evt_t evt, // Receiver event pulses.
  input wire logic [7:0] irq_mask_ab, // Mask for A and B, one disables.
  input wire logic [7:0] irq_mask_cd, // Mask for C and D, one disables.
  output logic irq // Interrupt output, active high.
);

  logic [7:0] on_c_low, on_d_low, irq_ab, irq_cd, peak, tick_cnt, set_ab, set_cd;
  logic [5:0] on_c_high, on_d_high, mode_one, pre_cnt;
  logic [3:0] ext_cmd;
  logic [14:0] on_left;
  rmirq_hold_t hs;
  logic [15:0] hop_cnt;
  logic ext_mode, hold_req;

  // Turns a 14-bit on-time count into ticks; zero stands for the full range.
  function automatic logic [14:0] ticks_of(input logic [5:0] hi, input logic [7:0] lo);
    logic [13:0] c;
    c = {hi, lo};
    ticks_of = (c == 14'h0000) ? `RMIRQ_ON_TIME_MAX : {1'b0, c};
  endfunction
  // Write decode for one address.
  function automatic logic wr_hit(input rmirq_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction
  // Register writes for the on-time halves.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      on_c_low <= `RMIRQ_RST_ON_LOW;
      on_c_high <= `RMIRQ_RST_ON_HIGH;
      on_d_low <= `RMIRQ_RST_ON_LOW;
      on_d_high <= `RMIRQ_RST_ON_HIGH;
    end else if (ce) begin
      if (wr_hit(req, `RMIRQ_OFS_ON_C_LOW)) begin
        on_c_low <= req.wdata;
      end else if (wr_hit(req, `RMIRQ_OFS_ON_C_HIGH)) begin
        on_c_high <= req.wdata[5:0];
      end else if (wr_hit(req, `RMIRQ_OFS_ON_D_LOW)) begin
        on_d_low <= req.wdata;
      end else if (wr_hit(req, `RMIRQ_OFS_ON_D_HIGH)) begin
        on_d_high <= req.wdata[5:0];
      end
    end
  end
  // Effective on-time lengths in ticks.
  assign on_time_c_ticks = ticks_of(on_c_high, on_c_low);
  assign on_time_d_ticks = ticks_of(on_d_high, on_d_low);
  // Mode control registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_one <= `RMIRQ_RST_MODE_ONE;
      mode_zero <= `RMIRQ_RST_MODE_ZERO;
    end else if (ce) begin
      if (wr_hit(req, `RMIRQ_OFS_MODE_ONE)) begin
        mode_one <= req.wdata[5:0];
      end else if (wr_hit(req, `RMIRQ_OFS_MODE_ZERO)) begin
        mode_zero <= req.wdata;
      end
    end
  end
  // Command bits hold for one cycle after the write, then clear themselves.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_cmd <= 4'h0;
    end else if (ce) begin
      if (wr_hit(req, `RMIRQ_OFS_EXT_CMD)) begin
        ext_cmd <= req.wdata[3:0];
      end else begin
        ext_cmd <= 4'h0;
      end
    end
  end
  // Freeze levels follow the last command write while the source is the command.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gain_freeze <= 1'b0;
      freq_freeze <= 1'b0;
    end else if (ce) begin
      if (!gain_freeze_source) begin
        gain_freeze <= 1'b0;
      end else if (wr_hit(req, `RMIRQ_OFS_EXT_CMD)) begin
        gain_freeze <= req.wdata[`RMIRQ_CMD_GAIN];
      end
      if (!freq_freeze_source) begin
        freq_freeze <= 1'b0;
      end else if (wr_hit(req, `RMIRQ_OFS_EXT_CMD)) begin
        freq_freeze <= req.wdata[`RMIRQ_CMD_FREQ];
      end
    end
  end
  // Forced timeout and message end merge with the internal ones.
  assign ext_mode = (external_processing_select == 2'h1) || (external_processing_select == 2'h2);
  assign message_timeout = message_timeout_in || (ext_mode && ext_cmd[`RMIRQ_CMD_TIMEOUT]);
  assign message_end = message_end_in || (ext_mode && ext_cmd[`RMIRQ_CMD_END]);
  // Resume decision after message end or timeout in run mode self polling.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resume_valid <= 1'b0;
      resume_kind <= RMIRQ_RESUME_CFG_A;
    end else if (ce) begin
      resume_valid <= 1'b0;
      if (op_mode == RMIRQ_MODE_RUN_SELF_POLL) begin
        if (message_end) begin
          resume_valid <= 1'b1;
          resume_kind <= mode_one[`RMIRQ_M1_NEXT_CFG] ? RMIRQ_RESUME_NEXT_CFG : RMIRQ_RESUME_CFG_A;
        end else if (message_timeout) begin
          resume_valid <= 1'b1;
          if (!mode_one[`RMIRQ_M1_NEXT_CH]) begin
            resume_kind <= RMIRQ_RESUME_CFG_A;
          end else if (single_channel) begin
            resume_kind <= RMIRQ_RESUME_NEXT_CFG;
          end else begin
            resume_kind <= RMIRQ_RESUME_NEXT_CH;
          end
        end
      end
    end
  end
  // Queue initialisation at cycle start or frame start.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      queue_init <= 1'b0;
    end else if (ce) begin
      queue_init <= (mode_one[`RMIRQ_M1_INIT_CYCLE] && ((op_mode == RMIRQ_MODE_SLAVE_SLEEP && slave_cycle_start)
                    || (op_mode == RMIRQ_MODE_SELF_POLL && wake_to_run)))
                    || (mode_one[`RMIRQ_M1_INIT_FRAME] && frame_start);
    end
  end
  // Queue lock holds from message end until released; release loses to a new end.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      queue_locked <= 1'b0;
    end else if (ce) begin
      if (mode_one[`RMIRQ_M1_LOCK] && message_end) begin
        queue_locked <= 1'b1;
      end else if (queue_release) begin
        queue_locked <= 1'b0;
      end
    end
  end

  // Crystal precision and slave receiver state from the mode bits.
  assign crystal_precise = mode_one[`RMIRQ_M1_XTAL] && receiver_sleep;
  assign receiver_sleep = (op_mode == RMIRQ_MODE_SLAVE_SLEEP) && !mode_zero[`RMIRQ_M0_SLRX];
  assign receiver_slave = (op_mode == RMIRQ_MODE_SLAVE_SLEEP) && mode_zero[`RMIRQ_M0_SLRX];

  // Clock pin is driven only while enabled.
  assign clk_out_oe = mode_zero[`RMIRQ_M0_CLKOUT];
  assign clk_out = prog_clk && mode_zero[`RMIRQ_M0_CLKOUT];

  // Single configuration in slave, growing set in self polling.
  always_comb begin
    active_configs = 4'h0;
    if (op_mode == RMIRQ_MODE_SLAVE_SLEEP) begin
      active_configs[mode_zero[`RMIRQ_M0_MCS_HI:`RMIRQ_M0_MCS_LO]] = 1'b1;
    end else begin
      for (int i = 0; i < 4; i++) begin
        active_configs[i] = (2'(i) <= mode_zero[`RMIRQ_M0_MCS_HI:`RMIRQ_M0_MCS_LO]);
      end
    end
  end

  // Hold sequence: stay in hold, then optionally reinit the synthesiser and wait a hop time.
  assign hold_req = (op_mode == RMIRQ_MODE_SLAVE_SLEEP) && mode_zero[`RMIRQ_M0_HOLD];
  assign hold_state = (hs == RMIRQ_HS_HOLD);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hs <= RMIRQ_HS_RUN;
      hop_cnt <= 16'h0000;
      synth_init <= 1'b0;
      rx_init <= 1'b0;
    end else if (ce) begin
      synth_init <= 1'b0;
      rx_init <= 1'b0;
      case (hs)
        RMIRQ_HS_RUN: begin
          if (hold_req) begin
            hs <= RMIRQ_HS_HOLD;
          end
        end
        RMIRQ_HS_HOLD: begin
          if (!hold_req) begin
            if (mode_zero[`RMIRQ_M0_REINIT] && new_channel) begin
              hs <= RMIRQ_HS_HOP;
              synth_init <= 1'b1;
              hop_cnt <= 16'(HOP_CYCLES - 1);
            end else begin
              hs <= RMIRQ_HS_RUN;
              rx_init <= 1'b1;
            end
          end
        end
        RMIRQ_HS_HOP: begin
          if (hop_cnt == 16'h0000) begin
            hs <= RMIRQ_HS_RUN;
            rx_init <= 1'b1;
          end else begin
            hop_cnt <= hop_cnt - 16'h0001;
          end
        end
        default: begin
          hs <= RMIRQ_HS_RUN;
        end
      endcase
    end
  end

  // Reference tick: prescale by 64, then by the setting, zero counting as 256.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_cnt <= 6'h00;
      tick_cnt <= 8'h00;
      ref_tick <= 1'b0;
    end else if (ce) begin
      ref_tick <= 1'b0;
      if (pre_cnt == 6'(TICK_PRESCALE - 1)) begin
        pre_cnt <= 6'h00;
        if (tick_cnt == reference_timer_setting - 8'h01) begin
          tick_cnt <= 8'h00;
          ref_tick <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 8'h01;
        end
      end else begin
        pre_cnt <= pre_cnt + 6'h01;
      end
    end
  end

  // On-time window counts reference ticks; the count is taken at the start.
  assign on_time_busy = (on_left != 15'h0000);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      on_left <= 15'h0000;
      on_time_expired <= 1'b0;
    end else if (ce) begin
      on_time_expired <= 1'b0;
      if (on_time_start) begin
        on_left <= on_time_sel_d ? on_time_d_ticks : on_time_c_ticks;
      end else if (on_time_busy && ref_tick) begin
        on_left <= on_left - 15'h0001;
        on_time_expired <= (on_left == 15'h0001);
      end
    end
  end

  // Peak level taken at each wake event and cycle end; only reset clears it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      peak <= 8'h00;
    end else if (ce) begin
      if (evt.wake_found || cycle_end) begin
        peak <= peak_level;
      end
    end
  end

  // Event bits land in the low nibble for A and C, high nibble for B and D.
  always_comb begin
    set_ab = 8'h00;
    set_cd = 8'h00;
    case (evt_cfg)
      2'h0: set_ab[3:0] = evt;
      2'h1: set_ab[7:4] = evt;
      2'h2: set_cd[3:0] = evt;
      default: set_cd[7:4] = evt;
    endcase
  end

  // Status flags: a read clears, a same-cycle event still sets.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ab <= `RMIRQ_RST_IRQ;
      irq_cd <= `RMIRQ_RST_IRQ;
    end else if (ce) begin
      if (req.rd && req.addr == `RMIRQ_OFS_IRQ_AB) begin
        irq_ab <= set_ab;
      end else begin
        irq_ab <= irq_ab | set_ab;
      end
      if (req.rd && req.addr == `RMIRQ_OFS_IRQ_CD) begin
        irq_cd <= set_cd;
      end else begin
        irq_cd <= irq_cd | set_cd;
      end
    end
  end

  // Interrupt from flags whose mask bit is zero.
  assign irq = |(irq_ab & ~irq_mask_ab) || |(irq_cd & ~irq_mask_cd);

  // Read data; write-only and unmapped addresses read as zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce && req.rd) begin
      if (req.addr == `RMIRQ_OFS_PEAK) begin
        rdata <= peak;
      end else if (req.addr == `RMIRQ_OFS_IRQ_AB) begin
        rdata <= irq_ab;
      end else if (req.addr == `RMIRQ_OFS_IRQ_CD) begin
        rdata <= irq_cd;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  AST_ON_C_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    ({on_c_high, on_c_low} == 14'h0000) |-> (on_time_c_ticks == 15'h4000))
    else $error("zero C on-time must mean 16384 ticks");
  AST_CMD_ONESHOT: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !req.wr) |=> (ext_cmd == 4'h0))
    else $error("command bits did not self clear");
  AST_FORCE_END: assert property (@(posedge clk_sys) disable iff (rst)
    (ext_mode && ext_cmd[0]) |-> message_end)
    else $error("forced message end missing");
  AST_RESUME_A: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && op_mode == RMIRQ_MODE_RUN_SELF_POLL && message_end && !mode_one[5])
    |=> (resume_valid && resume_kind == RMIRQ_RESUME_CFG_A))
    else $error("resume after end not configuration A");
  AST_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && message_end && mode_one[1]) |=> queue_locked)
    else $error("queue not locked at message end");
  AST_CLKPIN: assert property (@(posedge clk_sys) disable iff (rst)
    !mode_zero[4] |-> (!clk_out_oe && !clk_out))
    else $error("clock pin driven while disabled");
  AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && evt_cfg == 2'h0 && evt.wake_found) |=> irq_ab[0])
    else $error("wake flag of A lost");
  AST_READ_CLR: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && req.rd && req.addr == 8'ha9 && evt == 4'h0) |=> (irq_cd == 8'h00))
    else $error("status read did not clear");
  AST_MASK: assert property (@(posedge clk_sys) disable iff (rst)
    ((irq_ab & ~irq_mask_ab) == 8'h00 && (irq_cd & ~irq_mask_cd) == 8'h00) |-> !irq)
    else $error("masked flag raised interrupt");
  AST_HOP: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && synth_init) |-> !rx_init ##1 (hs == RMIRQ_HS_HOP))
    else $error("receiver init not delayed by hop");
  AST_PEAK: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && cycle_end) |=> (peak == $past(peak_level)))
    else $error("peak level not captured");

endmodule

// ### rmirq_host.sv
`timescale 1ns/1ps
module rmirq_host import rmirq_pkg::*; (
  input wire logic clk_sys, // System clock.
  output rmirq_req_t req // Register strobe to the device.
);
  // The bus stays idle until the first access.
  initial begin
    req = '0;
  end
  // One write strobe, held over a single rising edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    req = '0;
  endtask
  // One read strobe; the data is registered at the strobe's edge.
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk_sys);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    req = '0;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rmirq_pkg::*;
  logic clk_sys, rst, ce, ref_tick, on_time_start, on_time_sel_d, on_time_busy, on_time_expired;
  logic gain_freeze_source, freq_freeze_source, gain_freeze, freq_freeze, message_timeout_in, message_end_in;
  logic message_timeout, message_end, single_channel, resume_valid, slave_cycle_start, wake_to_run;
  logic frame_start, queue_init, queue_release, queue_locked, crystal_precise, new_channel, hold_state;
  logic synth_init, rx_init, prog_clk, clk_out, clk_out_oe, receiver_sleep, receiver_slave, cycle_end, irq;
  logic [7:0] rdata, reference_timer_setting, mode_zero, peak_level, irq_mask_ab, irq_mask_cd;
  logic [14:0] on_time_c_ticks, on_time_d_ticks;
  logic [1:0] external_processing_select, evt_cfg;
  logic [3:0] active_configs;
  rmirq_req_t req;
  rmirq_mode_t op_mode;
  rmirq_resume_t resume_kind, last_kind;
  rmirq_evt_t evt;
  int num_errors, samples_checked, n_end, n_res, n_exp;
  rmirq_host host (.clk_sys(clk_sys), .req(req));
  rmirq_top #(.TICK_PRESCALE(2), .HOP_CYCLES(2)) dut (.clk_sys, .rst, .ce, .req, .rdata,
    .reference_timer_setting, .ref_tick, .on_time_start, .on_time_sel_d, .on_time_busy, .on_time_expired,
    .on_time_c_ticks, .on_time_d_ticks, .gain_freeze_source, .freq_freeze_source, .gain_freeze, .freq_freeze,
    .external_processing_select, .message_timeout_in, .message_end_in, .message_timeout, .message_end,
    .op_mode, .single_channel, .resume_valid, .resume_kind, .slave_cycle_start, .wake_to_run, .frame_start,
    .queue_init, .queue_release, .queue_locked, .crystal_precise, .new_channel, .hold_state, .synth_init,
    .rx_init, .prog_clk, .clk_out, .clk_out_oe, .active_configs, .receiver_sleep, .receiver_slave, .mode_zero,
    .peak_level, .cycle_end, .evt_cfg, .evt, .irq_mask_ab, .irq_mask_cd, .irq);
  // The clock toggles every half period of 10 ns.
  always #10 clk_sys = ~clk_sys;
  // Pulses and resume events are counted at each rising edge.
  always @(posedge clk_sys) begin
    if (message_end === 1'b1) n_end++;
    if (on_time_expired === 1'b1) n_exp++;
    if (resume_valid === 1'b1) begin
      n_res++;
      last_kind = resume_kind;
    end
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register and pin values straight after reset.
  task automatic t_reset();
    chk("clk_oe", {15'h0, clk_out_oe}, 16'h1);
    chk("mode_zero", {8'h0, mode_zero}, 16'h10);
    chk("c_ticks", {1'b0, on_time_c_ticks}, 16'h1);
    chk("d_ticks", {1'b0, on_time_d_ticks}, 16'h1);
    chk("irq", {15'h0, irq}, 16'h1);
    irq_mask_ab = 8'hff;
    irq_mask_cd = 8'hff;
    prog_clk = 1'b1;
    @(negedge clk_sys);
    chk("irq_all_masked", {15'h0, irq}, 16'h0);
    chk("clk_pin", {15'h0, clk_out}, 16'h1);
    irq_mask_ab = 8'h00;
    irq_mask_cd = 8'h00;
    host.rd_reg(8'ha8);
    chk("stat_ab", {8'h0, rdata}, 16'hff);
    host.rd_reg(8'ha9);
    chk("stat_cd", {8'h0, rdata}, 16'hff);
    host.rd_reg(8'ha8);
    chk("stat_ab_clr", {8'h0, rdata}, 16'h0);
    chk("irq_clr", {15'h0, irq}, 16'h0);
    $display("test reset done");
  endtask
  // Both halves written; a zero count stands for 16384 ticks.
  task automatic t_ontime();
    host.wr_reg(8'ha0, 8'h00);
    host.wr_reg(8'ha1, 8'h00);
    host.wr_reg(8'ha2, 8'h34);
    host.wr_reg(8'ha3, 8'hff);
    chk("c_zero", {1'b0, on_time_c_ticks}, 16'h4000);
    chk("d_max", {1'b0, on_time_d_ticks}, 16'h3f34);
    ce = 1'b0;
    host.wr_reg(8'ha3, 8'h00);
    ce = 1'b1;
    chk("ce_frozen", {1'b0, on_time_d_ticks}, 16'h3f34);
    host.wr_reg(8'ha2, 8'h02);
    host.wr_reg(8'ha3, 8'h00);
    reference_timer_setting = 8'h02;
    on_time_sel_d = 1'b1;
    on_time_start = 1'b1;
    @(negedge clk_sys);
    on_time_start = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("busy", {15'h0, on_time_busy}, 16'h1);
    repeat (9) @(negedge clk_sys);
    chk("done", {15'h0, on_time_busy}, 16'h0);
    chk("exp_n", n_exp[15:0], 16'h1);
    $display("test on-time done");
  endtask
  // Events land in the nibble of their configuration; masking gates the output.
  task automatic t_irq();
    host.rd_reg(8'ha9);
    @(negedge clk_sys);
    evt_cfg = 2'h2;
    evt = '{1'b0, 1'b0, 1'b0, 1'b1};
    @(negedge clk_sys);
    evt_cfg = 2'h1;
    evt = '{1'b1, 1'b0, 1'b0, 1'b0};
    @(negedge clk_sys);
    evt = '0;
    chk("irq_set", {15'h0, irq}, 16'h1);
    host.rd_reg(8'ha9);
    chk("stat_c", {8'h0, rdata}, 16'h01);
    irq_mask_ab = 8'h80;
    @(negedge clk_sys);
    chk("irq_masked", {15'h0, irq}, 16'h0);
    host.rd_reg(8'ha8);
    chk("stat_b", {8'h0, rdata}, 16'h80);
    irq_mask_ab = 8'h00;
    $display("test irq done");
  endtask
  // Command bits act once; forcing needs external processing.
  task automatic t_cmd();
    n_end = 0;
    host.wr_reg(8'ha4, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk("end_internal", n_end[15:0], 16'h0);
    external_processing_select = 2'h1;
    host.wr_reg(8'ha4, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk("end_forced", n_end[15:0], 16'h1);
    gain_freeze_source = 1'b1;
    freq_freeze_source = 1'b1;
    host.wr_reg(8'ha4, 8'h0c);
    @(negedge clk_sys);
    chk("gain_frz", {15'h0, gain_freeze}, 16'h1);
    chk("freq_frz", {15'h0, freq_freeze}, 16'h1);
    host.wr_reg(8'ha4, 8'h00);
    @(negedge clk_sys);
    chk("gain_free", {15'h0, gain_freeze}, 16'h0);
    chk("freq_free", {15'h0, freq_freeze}, 16'h0);
    $display("test command done");
  endtask
  // Mode fields, resume choice and peak capture.
  task automatic t_mode();
    host.wr_reg(8'ha6, 8'h0e);
    chk("cfg_one", {12'h0, active_configs}, 16'h8);
    chk("clk_off", {15'h0, clk_out_oe}, 16'h0);
    chk("slave", {15'h0, receiver_slave}, 16'h1);
    op_mode = RMIRQ_MODE_SELF_POLL;
    @(negedge clk_sys);
    chk("cfg_set", {12'h0, active_configs}, 16'hf);
    op_mode = RMIRQ_MODE_RUN_SELF_POLL;
    host.wr_reg(8'ha5, 8'h24);
    n_res = 0;
    message_end_in = 1'b1;
    @(negedge clk_sys);
    message_end_in = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("resume", {14'h0, last_kind}, {14'h0, RMIRQ_RESUME_NEXT_CFG});
    chk("resume_n", n_res[15:0], 16'h1);
    host.wr_reg(8'ha5, 8'h17);
    message_timeout_in = 1'b1;
    @(negedge clk_sys);
    message_timeout_in = 1'b0;
    @(negedge clk_sys);
    chk("to_next_ch", {14'h0, last_kind}, {14'h0, RMIRQ_RESUME_NEXT_CH});
    single_channel = 1'b1;
    host.wr_reg(8'ha4, 8'h02);
    repeat (2) @(negedge clk_sys);
    chk("to_next_cfg", {14'h0, last_kind}, {14'h0, RMIRQ_RESUME_NEXT_CFG});
    chk("to_n", n_res[15:0], 16'h3);
    message_end_in = 1'b1;
    frame_start = 1'b1;
    @(negedge clk_sys);
    message_end_in = 1'b0;
    frame_start = 1'b0;
    queue_release = 1'b1;
    chk("q_init", {15'h0, queue_init}, 16'h1);
    chk("q_lock", {15'h0, queue_locked}, 16'h1);
    @(negedge clk_sys);
    queue_release = 1'b0;
    chk("q_free", {15'h0, queue_locked}, 16'h0);
    peak_level = 8'h5a;
    cycle_end = 1'b1;
    @(negedge clk_sys);
    cycle_end = 1'b0;
    host.rd_reg(8'ha7);
    chk("peak", {8'h0, rdata}, 16'h5a);
    $display("test mode done");
  endtask
  // Hold with a new channel: synthesiser restart, hop wait, then receiver start.
  task automatic t_hold();
    op_mode = RMIRQ_MODE_SLAVE_SLEEP;
    new_channel = 1'b1;
    host.wr_reg(8'ha6, 8'h70);
    chk("xtal", {15'h0, crystal_precise}, 16'h1);
    chk("sleep", {15'h0, receiver_sleep}, 16'h1);
    @(negedge clk_sys);
    chk("hold", {15'h0, hold_state}, 16'h1);
    host.wr_reg(8'ha6, 8'h50);
    @(negedge clk_sys);
    chk("synth", {15'h0, synth_init}, 16'h1);
    @(negedge clk_sys);
    chk("rx_wait", {15'h0, rx_init}, 16'h0);
    @(negedge clk_sys);
    chk("rx_init", {15'h0, rx_init}, 16'h1);
    $display("test hold done");
  endtask
  // Stimulus at time zero, reset for 12 cycles, then the tests.
  initial begin
    clk_sys = 0; rst = 1; ce = 1; on_time_start = 0; on_time_sel_d = 0; gain_freeze_source = 0;
    freq_freeze_source = 0; message_timeout_in = 0; message_end_in = 0; single_channel = 0;
    slave_cycle_start = 0; wake_to_run = 0; frame_start = 0; queue_release = 0; new_channel = 0;
    prog_clk = 0; cycle_end = 0; reference_timer_setting = 8'h01; peak_level = 8'h00; irq_mask_ab = 8'h00;
    irq_mask_cd = 8'h00; external_processing_select = 2'h0; evt_cfg = 2'h0; evt = '0;
    op_mode = RMIRQ_MODE_SLAVE_SLEEP; num_errors = 0; samples_checked = 0; n_end = 0; n_res = 0;
    repeat (12) @(negedge clk_sys);
    rst = 0;
    t_reset();
    t_ontime();
    t_irq();
    t_cmd();
    t_mode();
    t_hold();
    wrap_up();
  end
  // Cuts a hang short well beyond the expected run of about 100 cycles.
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end
endmodule
